/* File: hw/purge_defines.vh */
// Constants for the enclosure purge sequencer
// Assumes inclusion by bare name from design files
`ifndef PURGE_DEFINES_VH
`define PURGE_DEFINES_VH
`define PH_PREP          2'h0
`define PH_PURGE         2'h1
`define PH_OPER          2'h2
`define SEL_NORMAL       4'h0
`define SEL_PURGE_TIME   4'h2
`define SEL_BYPASS       4'h9
`define MIN_W            8
`define CLK_HZ           36'h5f5e100
`define SEC_PER_MIN      36'h3c
`define MIN_CYCLES       (`CLK_HZ * `SEC_PER_MIN)
`define AUX_FN_OPER      2'h0
`define AUX_FN_READY     2'h1
`define AUX_FN_ALARM     2'h2
`define AUX_FN_OFF       2'h3
`endif

/* File: hw/sync2.v */
// Two flip-flop synchroniser for a bus of levels
// Assumes inputs are asynchronous to clk_i
`timescale 1ns/100ps
module sync2 #(
   parameter W = 1
) (
   input  wire         clk_i,
   input  wire         rst_n_i,
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] meta;
   reg [W-1:0] stab;
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta <= {W{1'b0}};
         stab <= {W{1'b0}};
      end else begin
         meta <= d_i;
         stab <= meta;
      end
   end
   assign q_o = stab;
endmodule // sync2

/* File: hw/enclosure_purge_sequencer.v */
// Phase sequencer for a pressurised-enclosure controller
// Assumes comparator, selector and jumper inputs are asynchronous pins
`timescale 1ns/100ps
`include "purge_defines.vh"
module enclosure_purge_sequencer #(
   parameter [35:0] MIN_CYCLES = `MIN_CYCLES
) (
   input  wire              clk_i,
   input  wire              rst_n_i,
   input  wire              power_ok_i,
   input  wire              dust_zone_i,
   input  wire              above_min_i,
   input  wire              above_purge_i,
   input  wire              above_max_i,
   input  wire [3:0]        selector_i,
   input  wire              bypass_jumper_i,
   input  wire [`MIN_W-1:0] purge_minutes_i,
   input  wire [1:0]        aux_function_i,
   output reg  [1:0]        phase_o,
   output reg               purge_valve_o,
   output reg               enable_relay_o,
   output reg               enable_led_o,
   output reg               aux_relay_o,
   output reg               alarm_o,
   output reg               bypass_display_o,
   output reg               show_pressure_o,
   output reg  [`MIN_W-1:0] remain_minutes_o,
   output reg  [5:0]        remain_seconds_o
);
   wire [5:0] pin_sync;
   wire       s_pow;
   wire       s_min;
   wire       s_prg;
   wire       s_max;
   wire       s_jmp;
   wire       s_dust;
   wire [3:0] s_sel;
   reg  [1:0] phase;
   reg  [`MIN_W-1:0] min_cnt;
   reg  [5:0]  sec_cnt;
   reg  [31:0] tick_cnt;
   reg         bypass;
   reg  [1:0]  next_phase;
   wire        in_window;
   wire        purge_ok;
   wire        done;
   wire        tick;
   wire        sec_tick;

   // Cycles in one purge second and the last count of the tick counter
   localparam [35:0] SEC_CYCLES = MIN_CYCLES / `SEC_PER_MIN;
   localparam [31:0] SEC_LAST   = SEC_CYCLES[31:0] - 32'h1;

   // enable decode for relay and indicator
   function enable_ok;
      input [1:0] ph;
      input       mn;
      input       mx;
      input       dz;
      input       byp;
      begin
         enable_ok = (ph == `PH_OPER) && ((mn && (dz || !mx)) || byp);
      end
   endfunction

   function aux_decode;
      input [1:0] fn;
      input [1:0] ph;
      input       mn;
      begin
         case (fn)
            `AUX_FN_OPER: begin
               aux_decode = (ph == `PH_OPER);
            end
            `AUX_FN_READY: begin
               aux_decode = (ph == `PH_OPER) && mn;
            end
            `AUX_FN_ALARM: begin
               aux_decode = (ph == `PH_OPER) && !mn;
            end
            default: begin
               aux_decode = 1'b0;
            end
         endcase
      end
   endfunction

   sync2 #(.W(6)) u_sync_bits (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     ({power_ok_i, dust_zone_i, above_min_i, above_purge_i,
                 above_max_i, bypass_jumper_i}),
      .q_o     (pin_sync)
   );
   sync2 #(.W(4)) u_sync_sel (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (selector_i),
      .q_o     (s_sel)
   );
   assign s_pow  = pin_sync[5];
   assign s_dust = pin_sync[4];
   assign s_min  = pin_sync[3];
   assign s_prg  = pin_sync[2];
   assign s_max  = pin_sync[1];
   assign s_jmp  = pin_sync[0];

   assign in_window = s_min & ~s_max;
   assign purge_ok  = s_prg & ~s_max & s_min;
   assign done      = (min_cnt == {`MIN_W{1'b0}}) && (sec_cnt == 6'h0);
   assign tick      = (tick_cnt == SEC_LAST);
   // dust zone keeps the count still
   assign sec_tick  = tick & purge_ok & ~done & ~s_dust;

   always @* begin
      next_phase = phase;
      case (phase)
         `PH_PREP: begin
            if (s_dust) begin
               if (s_pow && s_min)
                  next_phase = `PH_OPER;
            end else if (s_pow && in_window && purge_minutes_i != {`MIN_W{1'b0}}) begin
               next_phase = `PH_PURGE;
            end
         end
         `PH_PURGE: begin
            if (done)
               next_phase = `PH_OPER;
         end
         `PH_OPER: begin
            if (!s_dust && !s_min && !bypass)
               next_phase = `PH_PURGE;
         end
         default: next_phase = `PH_PREP;
      endcase
      if (!s_pow)
         next_phase = `PH_PREP;
   end

   // Phase register
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         phase <= `PH_PREP;
      end else begin
         phase <= next_phase;
      end
   end

   // bypass latch, held while the jumper stays fitted
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         bypass <= 1'b0;
      end else begin
         bypass <= s_jmp && (bypass || (s_sel == `SEL_BYPASS));
      end
   end

   // one-second tick, restarted while out of limits
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         tick_cnt <= 32'h0;
      end else if (tick || !purge_ok) begin
         tick_cnt <= 32'h0;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
      end
   end

   // Purge countdown in minutes and seconds
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         min_cnt <= purge_minutes_i;
         sec_cnt <= 6'h0;
      // reload in preparation or on repurge
      end else if (phase == `PH_PREP || (phase == `PH_OPER && next_phase == `PH_PURGE)) begin
         min_cnt <= purge_minutes_i;
         sec_cnt <= 6'h0;
      end else if (bypass && phase == `PH_OPER && !s_min) begin
         min_cnt <= purge_minutes_i;
         sec_cnt <= 6'h0;
      end else if (sec_tick) begin
         if (sec_cnt == 6'h0) begin
            sec_cnt <= 6'h3b;
            min_cnt <= min_cnt - {{(`MIN_W-1){1'b0}}, 1'b1};
         end else begin
            sec_cnt <= sec_cnt - 6'h1;
         end
      end
   end

   // Phase output mirrors the phase register
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         phase_o <= `PH_PREP;
      end else begin
         phase_o <= next_phase;
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         purge_valve_o <= 1'b0;
      end else begin
         purge_valve_o <= (next_phase == `PH_PURGE);
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         enable_relay_o <= 1'b0;
      end else begin
         enable_relay_o <= enable_ok(next_phase, s_min, s_max, s_dust, bypass);
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         enable_led_o <= 1'b0;
      end else begin
         enable_led_o <= enable_ok(next_phase, s_min, s_max, s_dust, bypass);
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         aux_relay_o <= 1'b0;
      end else begin
         aux_relay_o <= aux_decode(aux_function_i, next_phase, s_min);
      end
   end

   // dust zone alarm, only while operating
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         alarm_o <= 1'b0;
      end else begin
         alarm_o <= s_dust && (next_phase == `PH_OPER) && !s_min;
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         bypass_display_o <= 1'b0;
      end else begin
         bypass_display_o <= bypass;
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         show_pressure_o <= 1'b0;
      end else begin
         show_pressure_o <= (next_phase == `PH_OPER);
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         remain_minutes_o <= {`MIN_W{1'b0}};
         remain_seconds_o <= 6'h0;
      end else begin
         remain_minutes_o <= min_cnt;
         remain_seconds_o <= sec_cnt;
      end
   end
endmodule // enclosure_purge_sequencer

/* File: verif/pressure_model.sv */
// Pressure comparator model for the sequencer bench
// Assumes the bench drives a pressure code on level_i
`timescale 1ns/100ps
module pressure_model #(parameter MN = 10, PG = 20, MX = 40) (
   input  wire [7:0] level_i,
   output wire       above_min_o,
   output wire       above_purge_o,
   output wire       above_max_o
);
   assign above_min_o   = level_i > MN;
   assign above_purge_o = level_i > PG;
   assign above_max_o   = level_i > MX;
endmodule // pressure_model

/* File: verif/purge_chk.sv */
// Port checker for the enclosure purge sequencer
// Assumes binding to the sequencer, pins lag three edges
`timescale 1ns/100ps
module purge_chk (
   input wire       clk_i,
   input wire       rst_n_i,
   input wire       dust_zone_i,
   input wire       above_min_i,
   input wire       above_purge_i,
   input wire       above_max_i,
   input wire [3:0] selector_i,
   input wire       bypass_jumper_i,
   input wire [1:0] phase_o,
   input wire       purge_valve_o,
   input wire       enable_relay_o,
   input wire       enable_led_o,
   input wire       alarm_o,
   input wire       bypass_display_o,
   input wire       show_pressure_o,
   input wire [5:0] remain_seconds_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire win = above_min_i && above_purge_i && !above_max_i;
   sequence s_low;
      !above_min_i && !bypass_display_o && !dust_zone_i;
   endsequence
   sequence s_purging;
      phase_o == 2'h1 && $past(phase_o) == 2'h1;
   endsequence
   AST_RESET: assert property (disable iff (1'b0) !rst_n_i |=>
      phase_o == 2'h0 && !purge_valve_o && !enable_relay_o) else $error("reset state wrong");
   AST_VALVE: assert property (purge_valve_o |-> phase_o == 2'h1)
      else $error("valve open outside purge");
   AST_FREEZE: assert property (s_purging ##0 $changed(remain_seconds_o) |->
      $past(win, 2) || $past(win, 3) || $past(win, 4) || $past(win, 5))
      else $error("countdown moved out of window");
   AST_ENABLE: assert property (enable_relay_o |-> phase_o == 2'h2)
      else $error("enable outside operation");
   AST_LED: assert property (enable_relay_o == enable_led_o)
      else $error("indicator differs from relay");
   AST_SHOW: assert property (phase_o == 2'h2 |-> show_pressure_o)
      else $error("operation not showing pressure");
   AST_DROP: assert property (s_low [*4] |-> !enable_relay_o)
      else $error("enable kept below minimum");
   AST_ALARM: assert property (alarm_o |-> phase_o == 2'h2)
      else $error("alarm outside operation");
   AST_BYPASS: assert property ($rose(bypass_display_o) |->
      $past(selector_i == 4'h9 && bypass_jumper_i, 3) ||
      $past(selector_i == 4'h9 && bypass_jumper_i, 4)) else $error("bypass without setup");
endmodule // purge_chk
bind enclosure_purge_sequencer purge_chk chk (
   .clk_i            (clk_i),
   .rst_n_i          (rst_n_i),
   .dust_zone_i      (dust_zone_i),
   .above_min_i      (above_min_i),
   .above_purge_i    (above_purge_i),
   .above_max_i      (above_max_i),
   .selector_i       (selector_i),
   .bypass_jumper_i  (bypass_jumper_i),
   .phase_o          (phase_o),
   .purge_valve_o    (purge_valve_o),
   .enable_relay_o   (enable_relay_o),
   .enable_led_o     (enable_led_o),
   .alarm_o          (alarm_o),
   .bypass_display_o (bypass_display_o),
   .show_pressure_o  (show_pressure_o),
   .remain_seconds_o (remain_seconds_o)
);

/* File: verif/enclosure_purge_sequencer_test.sv */
// Bench for the enclosure purge sequencer
// Assumes 100 MHz clock and ten cycles per purge second
`timescale 1ns/100ps
module enclosure_purge_sequencer_test;
   reg        clk_i = 1'b0, rst_n_i = 1'b0, power_ok_i = 1'b1;
   reg        dust_zone_i = 1'b0, bypass_jumper_i = 1'b0;
   reg  [7:0] lvl = 8'h00, purge_minutes_i = 8'h00;
   reg  [3:0] selector_i = 4'h0;
   reg  [1:0] aux_function_i = 2'h0;
   wire [1:0] phase_o;
   wire       above_min_i, above_purge_i, above_max_i, purge_valve_o, enable_relay_o;
   wire       enable_led_o, aux_relay_o, alarm_o, bypass_display_o, show_pressure_o;
   wire [7:0] remain_minutes_o;
   wire [5:0] remain_seconds_o;
   reg  [5:0] hold;
   integer    n_errors = 0, tests_run = 0, i;
   always #5 clk_i = ~clk_i;
   pressure_model pm (.level_i(lvl), .above_min_o(above_min_i), .above_purge_o(above_purge_i),
      .above_max_o(above_max_i));
   enclosure_purge_sequencer #(
      .MIN_CYCLES (36'h258)
   ) dut (
      .clk_i            (clk_i),
      .rst_n_i          (rst_n_i),
      .power_ok_i       (power_ok_i),
      .dust_zone_i      (dust_zone_i),
      .above_min_i      (above_min_i),
      .above_purge_i    (above_purge_i),
      .above_max_i      (above_max_i),
      .selector_i       (selector_i),
      .bypass_jumper_i  (bypass_jumper_i),
      .purge_minutes_i  (purge_minutes_i),
      .aux_function_i   (aux_function_i),
      .phase_o          (phase_o),
      .purge_valve_o    (purge_valve_o),
      .enable_relay_o   (enable_relay_o),
      .enable_led_o     (enable_led_o),
      .aux_relay_o      (aux_relay_o),
      .alarm_o          (alarm_o),
      .bypass_display_o (bypass_display_o),
      .show_pressure_o  (show_pressure_o),
      .remain_minutes_o (remain_minutes_o),
      .remain_seconds_o (remain_seconds_o)
   );
   task step(input integer n);
      repeat (n) @(negedge clk_i);
   endtask
   task chk(input [8*6-1:0] nm, input [7:0] exp, input [7:0] got);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("mismatch %0s expected %h seen %h", nm, exp, got);
      end
   endtask
   task complete_run;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task wait_ph(input [1:0] p);
      integer k;
      k = 0;
      while (phase_o !== p && k < 2000) begin
         step(1);
         k = k + 1;
      end
      chk("phase", {6'h0, p}, {6'h0, phase_o});
      if (phase_o !== p) complete_run;
   endtask
   initial begin
      step(10);
      chk("rst", 8'h00, {phase_o, purge_valve_o, enable_relay_o, aux_relay_o, alarm_o,
         bypass_display_o, show_pressure_o});
      rst_n_i = 1'b1;
      lvl = 8'h1e;
      step(8);
      chk("nocfg", 8'h00, {6'h0, phase_o});
      purge_minutes_i = 8'h01;
      wait_ph(2'h1);
      chk("valve", 8'h02, {6'h0, purge_valve_o, show_pressure_o});
      lvl = 8'h0f;
      step(5);
      hold = rsec_now();
      step(40);
      chk("halt", {2'h0, hold}, {2'h0, remain_seconds_o});
      lvl = 8'h1e;
      wait_ph(2'h2);
      chk("oper", 8'h07, {4'h0, purge_valve_o, enable_relay_o, enable_led_o, show_pressure_o});
      for (i = 0; i < 4; i = i + 1) begin
         aux_function_i = i[1:0];
         step(4);
         chk("aux", {7'h0, i < 2}, {7'h0, aux_relay_o});
      end
      lvl = 8'h00;
      step(5);
      chk("drop", 8'h01, {5'h0, enable_relay_o, phase_o});
      lvl = 8'h1e;
      wait_ph(2'h2);
      selector_i = 4'h9;
      bypass_jumper_i = 1'b1;
      step(5);
      chk("byp", 8'h01, {7'h0, bypass_display_o});
      lvl = 8'h00;
      step(20);
      chk("hold", 8'h06, {5'h0, enable_relay_o, phase_o});
      lvl = 8'h1e;
      step(5);
      hold = rsec_now();
      step(25);
      chk("count", 8'h01, {7'h0, remain_seconds_o !== hold});
      bypass_jumper_i = 1'b0;
      step(5);
      chk("byp", 8'h00, {7'h0, bypass_display_o});
      selector_i = 4'h0;
      rst_n_i = 1'b0;
      dust_zone_i = 1'b1;
      lvl = 8'h00;
      step(10);
      rst_n_i = 1'b1;
      lvl = 8'h1e;
      wait_ph(2'h2);
      chk("dust", 8'h01, {6'h0, purge_valve_o, enable_relay_o});
      step(30);
      chk("dmins", 8'h01, remain_minutes_o);
      chk("dsecs", 8'h00, {2'h0, remain_seconds_o});
      lvl = 8'h00;
      step(5);
      chk("alarm", 8'h01, {7'h0, alarm_o});
      power_ok_i = 1'b0;
      step(5);
      chk("nopow", 8'h00, {4'h0, alarm_o, enable_relay_o, phase_o});
      complete_run;
   end
   function [5:0] rsec_now;
      rsec_now = remain_seconds_o;
   endfunction
endmodule // enclosure_purge_sequencer_test
